/* File: bench/vic_cpu_model.sv */
// vic_cpu_model: processor core answering the two request lines
// assumes: registered outputs on sys_clk; vector read delay set by the bench
`timescale 1ns/100ps
`default_nettype none
module vic_cpu_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request lines from the controller
  input wire logic cpu_normal_irq_n,
  input wire logic cpu_fast_irq_n,
  // vector read latency in cycles; fast_ack is not delayed
  input wire logic [3:0] wait_cyc,
  // acknowledges to the controller
  output logic vec_rd,
  output logic fast_ack
);
  logic [3:0] cnt_ff;
  logic [1:0] hold_ff;

  // ----------------------------------------------------------------
  // read the vector once the normal line has been low long enough
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      hold_ff <= 2'h0;
      vec_rd <= 1'b0;
      fast_ack <= 1'b0;
    end else begin
      vec_rd <= 1'b0;
      fast_ack <= !cpu_fast_irq_n && !fast_ack;
      // registered line needs two cycles to drop after a read
      if (hold_ff != 2'h0) begin
        hold_ff <= hold_ff - 2'h1;
      end else if (!cpu_normal_irq_n && cnt_ff >= wait_cyc) begin
        vec_rd <= 1'b1;
        hold_ff <= 2'h3;
        cnt_ff <= 4'h0;
      end else if (!cpu_normal_irq_n) begin
        cnt_ff <= cnt_ff + 4'h1;
      end else begin
        cnt_ff <= 4'h0;
      end
    end
  end
endmodule // vic_cpu_model
`default_nettype wire

/* File: bench/vic_top_tb.sv */
// vic_top_tb: directed tests of the vectored interrupt controller
// assumes: vic_pkg, vic_src_if and the design files compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module vic_top_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fast_irq_in = 1'b0, system_periph_source = 1'b0, ext_irq_in_0 = 1'b0, ext_irq_in_1 = 1'b0;
  logic [vic_pkg::N_PERIPH-1:0] periph_irq = '0;
  logic [31:0] src_enable = 32'hFFFF_FFFF, src_edge_mode = 32'h0000_0000;
  logic [31:0] src_pol_high = 32'hFFFF_FFFF, fast_force = 32'h0000_0000;
  logic [31:0][vic_pkg::PRIO_W-1:0] src_prio = '0;
  logic general_mask = 1'b0, protect_mode = 1'b0, dbg_rd = 1'b0, eoi = 1'b0;
  logic vec_wr_en = 1'b0;
  logic [vic_pkg::SRC_W-1:0] vec_wr_idx = 5'h00;
  logic [31:0] vec_wr_data = 32'h0000_0000;
  logic vec_rd, fast_ack, cpu_normal_irq_n, cpu_fast_irq_n;
  logic [31:0] cur_vector, pending_status;
  logic [vic_pkg::SRC_W-1:0] cur_src;
  int n_errors = 0;
  int n_compared = 0;

  always #50 sys_clk = ~sys_clk;

  vic_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .fast_irq_in(fast_irq_in),
    .system_periph_source(system_periph_source), .periph_irq(periph_irq), .ext_irq_in_0(ext_irq_in_0),
    .ext_irq_in_1(ext_irq_in_1), .src_enable(src_enable), .src_edge_mode(src_edge_mode),
    .src_pol_high(src_pol_high), .src_prio(src_prio), .fast_force(fast_force), .general_mask(general_mask),
    .protect_mode(protect_mode), .vec_wr_en(vec_wr_en), .vec_wr_idx(vec_wr_idx), .vec_wr_data(vec_wr_data),
    .vec_rd(vec_rd), .dbg_rd(dbg_rd), .eoi(eoi), .fast_ack(fast_ack), .cpu_normal_irq_n(cpu_normal_irq_n),
    .cpu_fast_irq_n(cpu_fast_irq_n), .cur_vector(cur_vector), .cur_src(cur_src),
    .pending_status(pending_status));

  vic_cpu_model i_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_normal_irq_n(cpu_normal_irq_n),
    .cpu_fast_irq_n(cpu_fast_irq_n), .wait_cyc(4'h2), .vec_rd(vec_rd), .fast_ack(fast_ack));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // wait for the core's vector read, then compare what it returned
  task automatic wait_ack(input logic [4:0] src);
    int k;
    for (k = 0; k < 50 && vec_rd !== 1'b1; k++) tick(1);
    tick(1);
    `CHK("cur_src", src, cur_src)
    `CHK("cur_vector", {27'h500_0000, src}, cur_vector)
  endtask

  task automatic end_service();
    eoi = 1'b1;
    tick(1);
    eoi = 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int i;
    for (i = 0; i < 32; i++) src_prio[i] = 3'h1;
    src_prio[4] = 3'h2; src_prio[9] = 3'h5; src_prio[30] = 3'h6; src_prio[1] = 3'h3;
    src_prio[2] = 3'h4; src_prio[31] = 3'h7;
    tick(10);
    rst_n = 1'b1;
    tick(1);
    for (i = 0; i < 32; i++) begin
      vec_wr_en = 1'b1; vec_wr_idx = i[4:0]; vec_wr_data = {27'h500_0000, i[4:0]};
      tick(1);
    end
    vec_wr_en = 1'b0;
    // all inputs but the fast input high: reserved numbers must stay clear
    system_periph_source = 1'b1; periph_irq = '1; ext_irq_in_0 = 1'b1; ext_irq_in_1 = 1'b1;
    src_enable = 32'h0000_0000;
    tick(3);
    `CHK("pending_status", 32'hC00F_FFFE, pending_status)
    system_periph_source = 1'b0; periph_irq = '0; ext_irq_in_0 = 1'b0; ext_irq_in_1 = 1'b0;
    src_enable = 32'hFFFF_FFFF;
    tick(3);
    $display("test reserved done");
    // priority, end of service and nesting
    periph_irq[2] = 1'b1; periph_irq[7] = 1'b1;
    wait_ack(5'h09);
    tick(4);
    `CHK("normal line", 1'b1, cpu_normal_irq_n)
    periph_irq[7] = 1'b0;
    end_service();
    wait_ack(5'h04);
    ext_irq_in_0 = 1'b1;
    wait_ack(5'h1E);
    ext_irq_in_0 = 1'b0; periph_irq[2] = 1'b0;
    end_service();
    end_service();
    tick(3);
    `CHK("normal line", 1'b1, cpu_normal_irq_n)
    $display("test priority done");
    // general mask holds lines but keeps the event
    general_mask = 1'b1; system_periph_source = 1'b1;
    tick(4);
    `CHK("normal line", 1'b1, cpu_normal_irq_n)
    `CHK("pending_status", 1'b1, pending_status[1])
    general_mask = 1'b0;
    wait_ack(5'h01);
    system_periph_source = 1'b0;
    end_service();
    $display("test mask done");
    // fast forcing and the fast input
    fast_force[5] = 1'b1; periph_irq[3] = 1'b1;
    tick(3);
    `CHK("fast line", 1'b0, cpu_fast_irq_n)
    `CHK("normal line", 1'b1, cpu_normal_irq_n)
    periph_irq[3] = 1'b0;
    tick(3);
    `CHK("fast line", 1'b1, cpu_fast_irq_n)
    fast_irq_in = 1'b1;
    tick(3);
    `CHK("fast line", 1'b0, cpu_fast_irq_n)
    `CHK("normal line", 1'b1, cpu_normal_irq_n)
    fast_irq_in = 1'b0;
    tick(3);
    $display("test fast done");
    // falling edge on an external source
    ext_irq_in_1 = 1'b1;
    tick(1);
    src_edge_mode[31] = 1'b1; src_pol_high[31] = 1'b0;
    tick(2);
    ext_irq_in_1 = 1'b0;
    tick(1);
    ext_irq_in_1 = 1'b1;
    wait_ack(5'h1F);
    end_service();
    tick(3);
    `CHK("normal line", 1'b1, cpu_normal_irq_n)
    // internal edge source, debugger reads under protect mode
    src_edge_mode[2] = 1'b1; protect_mode = 1'b1; dbg_rd = 1'b1;
    periph_irq[0] = 1'b1;
    tick(1);
    periph_irq[0] = 1'b0;
    wait_ack(5'h02);
    tick(4);
    `CHK("normal line", 1'b0, cpu_normal_irq_n)
    dbg_rd = 1'b0;
    wait_ack(5'h02);
    tick(3);
    `CHK("normal line", 1'b1, cpu_normal_irq_n)
    end_service();
    $display("test edge done");
    close_out();
  end
endmodule // vic_top_tb
`default_nettype wire

/* File: rtl/vic_pkg.sv */
// vic_pkg: source numbering, masks, priority widths and reset values
// assumes: used by vic_top, vic_src_detect and the bench of the vectored interrupt controller
package vic_pkg;

  // ----------------------------------------------------------------
  // source numbering
  // ----------------------------------------------------------------
  localparam int N_SRC = 32;
  localparam int SRC_W = 5;
  localparam int SRC_FAST = 0;
  localparam int SRC_SYS = 1;
  localparam int SRC_PERIPH_LO = 2;
  localparam int SRC_PERIPH_HI = 19;
  localparam int N_PERIPH = SRC_PERIPH_HI - SRC_PERIPH_LO + 1;
  localparam int SRC_EXT0 = 30;
  localparam int SRC_EXT1 = 31;
  localparam int N_RSVD = SRC_EXT0 - SRC_PERIPH_HI - 1;

  // sources 20 to 29 never pend
  localparam logic [31:0] VALID_MASK = 32'hC00F_FFFF;
  // sources with programmable polarity
  localparam logic [31:0] EXT_MASK = 32'hC000_0001;
  // source 0 always routes to the fast line
  localparam logic [31:0] FAST_FIXED = 32'h0000_0001;

  // ----------------------------------------------------------------
  // priority
  // ----------------------------------------------------------------
  localparam int PRIO_W = 3;
  localparam int N_LVL = 8;

  typedef logic [PRIO_W-1:0] vic_prio_t;
  typedef logic [SRC_W-1:0] vic_src_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [N_LVL-1:0] RST_SERVICE = 8'h00;
  localparam vic_src_t RST_SRC = 5'h00;

endpackage

/* File: rtl/vic_src_detect.sv */
// vic_src_detect: edge or level sensing of all interrupt sources
// assumes: raw inputs synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module vic_src_detect (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // sources
  vic_src_if.det sif
);

  logic [31:0] prev_ff;
  logic [31:0] edge_ff;
  logic [31:0] nxt_prev;
  logic [31:0] nxt_edge;
  logic [31:0] pol_eff;
  logic [31:0] act;

  // ----------------------------------------------------------------
  // sensing
  // ----------------------------------------------------------------
  always_comb begin
    // internal sources are always active high
    pol_eff = sif.pol_high | ~vic_pkg::EXT_MASK;
    act = ~(sif.raw ^ pol_eff) & vic_pkg::VALID_MASK;
    nxt_prev = act;
    // new edge wins over a clear in the same cycle
    nxt_edge = ((edge_ff & ~sif.clr) | (act & ~prev_ff & sif.edge_mode)) & vic_pkg::VALID_MASK;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= vic_pkg::RST_WORD;
      edge_ff <= vic_pkg::RST_WORD;
    end else begin
      prev_ff <= nxt_prev;
      edge_ff <= nxt_edge;
    end
  end

  assign sif.pend = (sif.edge_mode & edge_ff) | (~sif.edge_mode & act);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  reserved_quiet_a: assert property (sif.pend[29:20] == 10'h000)
    else $error("reserved source became pending");
  edge_sticky_a: assert property (1'b1 |=> ((edge_ff & $past(edge_ff & ~sif.clr)) == $past(edge_ff & ~sif.clr)))
    else $error("edge pending lost without a clear");
  ext_low_level_a: assert property ((!sif.edge_mode[31] && !sif.pol_high[31]) |-> (sif.pend[31] == !sif.raw[31]))
    else $error("low level external source not followed");

endmodule // vic_src_detect
`default_nettype wire

/* File: rtl/vic_src_if.sv */
// vic_src_if: per-source sensing configuration and pending flags
// assumes: one controller end and one detector end on the same clock
`timescale 1ns/100ps
`default_nettype none
interface vic_src_if;
  logic [31:0] raw;
  logic [31:0] edge_mode;
  logic [31:0] pol_high;
  logic [31:0] clr;
  logic [31:0] pend;

  modport ctrl (output raw, output edge_mode, output pol_high, output clr, input pend);
  modport det (input raw, input edge_mode, input pol_high, input clr, output pend);
endinterface
`default_nettype wire

/* File: rtl/vic_top.sv */
// vic_top: vectored, prioritised interrupt controller with nesting
// assumes: all inputs synchronous to sys_clk; config held as plain ports
`timescale 1ns/100ps
`default_nettype none
// Operation
// - source 0 is fast input, drives fast line
// - source 1 is combined system peripheral request
// - internal sources: edge or level sensing selectable
// - external sources: rising, falling, high, low selectable
// - eight priority levels; highest pending drives normal line
// - higher priority request nests over serviced one
// - one writable 32-bit vector per source
// - vector read returns signalled source vector
// - protect mode: debugger reads change only cur_vector and cur_src
// - any source may be forced onto fast line
// - general mask blocks both lines, keeps events
// - sources 2 to 19 are on-chip peripherals
// - sources 30, 31 external; 20-29 never pend
module vic_top #(
  parameter logic [31:0] SPURIOUS_VEC = 32'h0000_0000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // interrupt sources
  input wire logic fast_irq_in,
  input wire logic system_periph_source,
  input wire logic [vic_pkg::N_PERIPH-1:0] periph_irq,
  input wire logic ext_irq_in_0,
  input wire logic ext_irq_in_1,
  // source configuration
  input wire logic [31:0] src_enable,
  input wire logic [31:0] src_edge_mode,
  input wire logic [31:0] src_pol_high,
  input wire logic [31:0][vic_pkg::PRIO_W-1:0] src_prio,
  input wire logic [31:0] fast_force,
  input wire logic general_mask,
  input wire logic protect_mode,
  // vector write
  input wire logic vec_wr_en,
  input wire logic [vic_pkg::SRC_W-1:0] vec_wr_idx,
  input wire logic [31:0] vec_wr_data,
  // service handshake
  input wire logic vec_rd,
  input wire logic dbg_rd,
  input wire logic eoi,
  input wire logic fast_ack,
  // processor side
  output logic cpu_normal_irq_n,
  output logic cpu_fast_irq_n,
  output logic [31:0] cur_vector,
  output logic [vic_pkg::SRC_W-1:0] cur_src,
  output logic [31:0] pending_status
);

  vic_src_if sif ();

  logic [31:0] vec_mem_ff [vic_pkg::N_SRC];
  logic [31:0] nxt_vec_mem [vic_pkg::N_SRC];
  logic [vic_pkg::N_LVL-1:0] service_ff;
  logic [vic_pkg::N_LVL-1:0] nxt_service;
  logic norm_n_ff;
  logic nxt_norm_n;
  logic fast_n_ff;
  logic nxt_fast_n;
  logic [31:0] cur_vec_ff;
  logic [31:0] nxt_cur_vec;
  vic_pkg::vic_src_t cur_src_ff;
  vic_pkg::vic_src_t nxt_cur_src;
  logic [31:0] pend_ff;
  logic [31:0] nxt_pend;

  logic [31:0] fast_sel;
  logic [31:0] norm_cand;
  logic found;
  vic_pkg::vic_prio_t best_prio;
  vic_pkg::vic_src_t best_idx;
  logic busy;
  vic_pkg::vic_prio_t cur_lvl;
  logic req;
  logic rd_live;
  logic ack;
  logic [vic_pkg::N_LVL-1:0] top_lvl_mask;
  logic [31:0] clr;

  // ----------------------------------------------------------------
  // source mapping
  // ----------------------------------------------------------------
  assign sif.raw = {ext_irq_in_1, ext_irq_in_0, {vic_pkg::N_RSVD{1'b0}}, periph_irq,
                    system_periph_source, fast_irq_in};
  assign sif.edge_mode = src_edge_mode;
  assign sif.pol_high = src_pol_high;
  assign sif.clr = clr;

  vic_src_detect u_detect (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sif(sif)
  );

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  always_comb begin
    fast_sel = fast_force | vic_pkg::FAST_FIXED;
    norm_cand = sif.pend & src_enable & ~fast_sel;
    found = 1'b0;
    best_prio = '0;
    best_idx = '0;
    // descending scan, ties go to the lower source number
    for (int i = vic_pkg::N_SRC - 1; i >= 0; i--) begin
      if (norm_cand[i] && (!found || src_prio[i] >= best_prio)) begin
        found = 1'b1;
        best_prio = src_prio[i];
        best_idx = vic_pkg::vic_src_t'(i);
      end
    end
  end

  always_comb begin
    busy = |service_ff;
    cur_lvl = '0;
    top_lvl_mask = '0;
    for (int l = 0; l < vic_pkg::N_LVL; l++) begin
      if (service_ff[l]) begin
        cur_lvl = vic_pkg::vic_prio_t'(l);
        top_lvl_mask = {{(vic_pkg::N_LVL - 1){1'b0}}, 1'b1} << l;
      end
    end
    // only a strictly higher level may interrupt a running service
    req = found && (!busy || best_prio > cur_lvl);
  end

  // ----------------------------------------------------------------
  // service state and vectors
  // ----------------------------------------------------------------
  always_comb begin
    // debugger reads under protect leave service and pending state alone; cur_vector and cur_src still load
    rd_live = vec_rd && !(protect_mode && dbg_rd);
    ack = rd_live && req;
    clr = '0;
    if (ack) begin
      clr[best_idx] = 1'b1;
    end
    if (fast_ack && !(protect_mode && dbg_rd)) begin
      clr = clr | (fast_sel & src_enable);
    end

    nxt_service = service_ff;
    if (eoi) begin
      nxt_service = nxt_service & ~top_lvl_mask;
    end
    if (ack) begin
      nxt_service[best_prio] = 1'b1;
    end

    nxt_cur_vec = cur_vec_ff;
    nxt_cur_src = cur_src_ff;
    if (vec_rd) begin
      nxt_cur_vec = req ? vec_mem_ff[best_idx] : SPURIOUS_VEC;
      nxt_cur_src = req ? best_idx : vic_pkg::RST_SRC;
    end

    for (int k = 0; k < vic_pkg::N_SRC; k++) begin
      nxt_vec_mem[k] = vec_mem_ff[k];
    end
    if (vec_wr_en) begin
      nxt_vec_mem[vec_wr_idx] = vec_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // processor lines
  // ----------------------------------------------------------------
  always_comb begin
    // events keep pending while the general mask holds both lines off
    nxt_norm_n = !(req && !general_mask);
    nxt_fast_n = !((|(sif.pend & fast_sel & src_enable)) && !general_mask);
    nxt_pend = sif.pend;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      service_ff <= vic_pkg::RST_SERVICE;
      norm_n_ff <= 1'b1;
      fast_n_ff <= 1'b1;
      cur_vec_ff <= vic_pkg::RST_WORD;
      cur_src_ff <= vic_pkg::RST_SRC;
      pend_ff <= vic_pkg::RST_WORD;
      for (int k = 0; k < vic_pkg::N_SRC; k++) begin
        vec_mem_ff[k] <= vic_pkg::RST_WORD;
      end
    end else begin
      service_ff <= nxt_service;
      norm_n_ff <= nxt_norm_n;
      fast_n_ff <= nxt_fast_n;
      cur_vec_ff <= nxt_cur_vec;
      cur_src_ff <= nxt_cur_src;
      pend_ff <= nxt_pend;
      for (int k = 0; k < vic_pkg::N_SRC; k++) begin
        vec_mem_ff[k] <= nxt_vec_mem[k];
      end
    end
  end

  assign cpu_normal_irq_n = norm_n_ff;
  assign cpu_fast_irq_n = fast_n_ff;
  assign cur_vector = cur_vec_ff;
  assign cur_src = cur_src_ff;
  assign pending_status = pend_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  gen_mask_a: assert property (general_mask |=> (cpu_normal_irq_n && cpu_fast_irq_n))
    else $error("line asserted under general mask");
  fast_src0_a: assert property ((!general_mask && sif.pend[0] && src_enable[0]) |=> !cpu_fast_irq_n)
    else $error("fast source did not drive fast line");
  force_fast_a: assert property ((!general_mask && |(sif.pend & fast_force & src_enable)) |=> !cpu_fast_irq_n)
    else $error("forced source did not drive fast line");
  forced_not_norm_a: assert property ((sif.pend & src_enable & ~fast_force & ~vic_pkg::FAST_FIXED) == 32'h0
                                      |=> cpu_normal_irq_n)
    else $error("normal line without a normal candidate");
  nest_req_a: assert property ((busy && found && best_prio > cur_lvl && !general_mask) |=> !cpu_normal_irq_n)
    else $error("higher priority did not nest");
  vec_read_a: assert property ((vec_rd && req) |=> (cur_vector == $past(vec_mem_ff[best_idx])
                               && cur_src == $past(best_idx)))
    else $error("current vector does not match signalled source");
  vec_write_a: assert property (vec_wr_en |=> vec_mem_ff[$past(vec_wr_idx)] == $past(vec_wr_data))
    else $error("vector write not stored");
  protect_read_a: assert property ((vec_rd && dbg_rd && protect_mode && !eoi) |=> $stable(service_ff))
    else $error("protected debugger read changed service state");
  eoi_release_a: assert property ((eoi && busy && !ack) |=> $countones(service_ff) == $countones($past(service_ff)) - 1)
    else $error("end of service did not release one level");
  ack_level_a: assert property ((ack && !eoi) |=> service_ff[$past(best_prio)])
    else $error("acknowledged level not marked in service");

endmodule // vic_top
`default_nettype wire
